// >>> hw/dts_cfg.svh
/*
  Offsets, field positions, masks and sizes of the debug trigger
  and status block. Assumes byte addresses on a 32-bit AHB-Lite bus.
*/
`ifndef DTS_CFG_SVH
`define DTS_CFG_SVH

`define DTS_OFF_CTRL    8'h00
`define DTS_OFF_SETUP   8'h04
`define DTS_OFF_STATUS  8'h08
`define DTS_OFF_FIFOH   8'h0c
`define DTS_OFF_FIFOL   8'h10
`define DTS_OFF_CMPA    8'h14
`define DTS_OFF_CMPB    8'h18
`define DTS_OFF_IRQS    8'h1c
`define DTS_OFF_IRQM    8'h20

`define DTS_CTRL_EN     7
`define DTS_CTRL_RUN    6
`define DTS_SET_QSEL    7
`define DTS_SET_BEGIN   6
`define DTS_SET_RSVD    8'h30

`define DTS_IRQ_DONE    0
`define DTS_IRQ_A       1
`define DTS_IRQ_B       2

`define DTS_HSIZE_WORD  3'h2
`define DTS_EVT_HI      8'h00
`define DTS_FIFO_DEPTH  8
`define DTS_FIFO_WIDTH  16

`endif

// >>> hw/dts_pkg.sv
/*
  Types of the debug trigger and status block.
  Assumes nothing of its surroundings.
*/
package dts_pkg;

  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_RDW  = 2'b01,
    BS_RDD  = 2'b11,
    BS_WR   = 2'b10
  } dts_bus_t;

  typedef enum logic [3:0] {
    TM_A      = 4'h0,
    TM_AORB   = 4'h1,
    TM_ATHENB = 4'h2,
    TM_EVB    = 4'h3,
    TM_AEVB   = 4'h4,
    TM_AANDB  = 4'h5,
    TM_ANOTB  = 4'h6,
    TM_IN     = 4'h7,
    TM_OUT    = 4'h8
  } dts_mode_t;

endpackage

// >>> hw/dts_top.sv
/*
  Debug trigger selection and trace status with an AHB-Lite slave.
  Assumes the bus monitor, opcode tracking and change-of-flow inputs
  come from logic on hclk, and that this is the only slave on hready.
*/
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dts_cfg.svh"

module dts_top
  import dts_pkg::*;
#(
  parameter int DEPTH = `DTS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // CPU bus monitor
  input  wire logic        mon_valid,
  input  wire logic [15:0] mon_addr,
  input  wire logic [7:0]  mon_data,
  // Opcode tracking
  input  wire logic        exec_valid,
  input  wire logic [15:0] exec_addr,
  // Change of flow
  input  wire logic        cof_valid,
  input  wire logic [15:0] cof_addr,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    dts_bus_t    bs;
    logic [7:0]  addr;
    logic [7:0]  ctrl;
    logic [7:0]  setup;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic        af;
    logic        bf;
    logic        a_seen;
    logic        trig;
    logic [3:0]  vcnt;
    logic [2:0]  ist;
    logic [2:0]  imsk;
    logic [31:0] rdata;
  } dts_st_t;

  dts_st_t     q;
  dts_st_t     d;
  dts_mode_t   mode;
  logic        armed;
  logic        evonly;
  logic        begin_tr;
  logic        ev;
  logic [15:0] ad;
  logic        ma;
  logic        mb;
  logic        dm;
  logic        hit;
  logic        push;
  logic        pop;
  logic        aph;
  logic        wr;
  logic        wr_ctrl;
  logic        start;
  logic        stop_evt;
  logic        cnt_full;
  logic [15:0] pdata;
  logic [15:0] fdout;

  function automatic logic dts_hit(
    input dts_mode_t   m,
    input logic        e,
    input logic [15:0] a,
    input logic [15:0] ca,
    input logic [15:0] cb,
    input logic        xa,
    input logic        xb,
    input logic        dmt,
    input logic        seen
  );
    logic r;
    r = 1'b0;
    case (m)
      TM_A:              r = xa;
      TM_AORB:           r = xa | xb;
      TM_ATHENB, TM_AEVB: r = xb & seen;
      TM_EVB:            r = xb;
      TM_AANDB:          r = xa & dmt;
      TM_ANOTB:          r = xa & ~dmt;
      TM_IN:             r = e && a >= ca && a <= cb;
      TM_OUT:            r = e && (a < ca || a > cb);
      default:           r = 1'b0;
    endcase
    return r;
  endfunction

  // Trigger decode
  assign armed    = q.ctrl[`DTS_CTRL_EN] & q.ctrl[`DTS_CTRL_RUN];
  assign mode     = dts_mode_t'(q.setup[3:0]);
  assign evonly   = mode == TM_EVB || mode == TM_AEVB;
  assign begin_tr = evonly | q.setup[`DTS_SET_BEGIN];
  // Tag qualification set compares executed opcode addresses, clear compares bus monitor addresses
  assign ev = q.setup[`DTS_SET_QSEL] ? exec_valid : mon_valid;
  assign ad = q.setup[`DTS_SET_QSEL] ? exec_addr : mon_addr;
  assign ma = ev && ad == q.cmpa;
  assign mb = ev && ad == q.cmpb;
  // Full modes compare comparator B against the data byte
  assign dm = mon_data == q.cmpb[7:0];
  assign hit = armed & dts_hit(mode, ev, ad, q.cmpa, q.cmpb,
                               ma, mb, dm, q.a_seen);

  // Capture
  assign cnt_full = q.vcnt == 4'(DEPTH);
  assign pdata = evonly ? {`DTS_EVT_HI, mon_data} : cof_addr;
  always_comb begin
    push = 1'b0;
    if (armed) begin
      if (evonly) begin
        push = hit && !cnt_full;
      end else if (begin_tr) begin
        push = cof_valid && (q.trig || hit) && !cnt_full;
      end else begin
        push = cof_valid && !hit;
      end
    end
  end
  assign stop_evt = armed &&
    (begin_tr ? push && q.vcnt == 4'(DEPTH - 1) : hit);

  // Bus decode
  assign aph     = hsel & hready & htrans[1] &
                   (hsize == `DTS_HSIZE_WORD);
  assign wr      = q.bs == BS_WR;
  assign wr_ctrl = wr && q.addr == `DTS_OFF_CTRL;
  assign start   = wr_ctrl && hwdata[`DTS_CTRL_EN] &&
                   hwdata[`DTS_CTRL_RUN] && !armed;
  // Reads while armed would break sequencing, so they never advance
  assign pop = q.bs == BS_RDW && q.addr == `DTS_OFF_FIFOL && !armed;

  dts_trace_fifo #(
    .W  (`DTS_FIFO_WIDTH),
    .D  (DEPTH)
  ) u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (start),
    .ovw     (!begin_tr),
    .push    (push),
    .wdata   (pdata),
    .pop     (pop),
    .rdata   (fdout),
    .full    (),
    .empty   ()
  );

  always_comb begin
    logic [2:0] sev;
    logic [2:0] clr;
    logic       keep;
    sev  = 3'h0;
    clr  = 3'h0;
    keep = 1'b0;
    d    = q;

    // Bus phases; reads take one wait state so hrdata is a flop
    case (q.bs)
      BS_RDW: begin
        d.bs = BS_RDD;
        case (q.addr)
          `DTS_OFF_CTRL:   d.rdata = {24'h0, q.ctrl};
          `DTS_OFF_SETUP:  d.rdata = {24'h0, q.setup};
          `DTS_OFF_STATUS: d.rdata = {24'h0, q.af, q.bf,
                                      armed, 1'b0, q.vcnt};
          `DTS_OFF_FIFOH:  d.rdata = {24'h0, fdout[15:8]};
          `DTS_OFF_FIFOL:  d.rdata = {24'h0, fdout[7:0]};
          `DTS_OFF_CMPA:   d.rdata = {16'h0, q.cmpa};
          `DTS_OFF_CMPB:   d.rdata = {16'h0, q.cmpb};
          `DTS_OFF_IRQS:   d.rdata = {29'h0, q.ist};
          `DTS_OFF_IRQM:   d.rdata = {29'h0, q.imsk};
          default:         d.rdata = 32'h0;
        endcase
      end
      default: begin
        if (aph) begin
          d.bs   = hwrite ? BS_WR : BS_RDW;
          d.addr = haddr[7:0];
        end else begin
          d.bs = BS_IDLE;
        end
      end
    endcase

    // Run sequencing
    if (armed) begin
      if (ma) begin
        d.af       = 1'b1;
        d.a_seen   = 1'b1;
        sev[`DTS_IRQ_A] = 1'b1;
      end
      if (mb) begin
        d.bf       = 1'b1;
        sev[`DTS_IRQ_B] = 1'b1;
      end
      if (hit) begin
        d.trig = 1'b1;
      end
      if (push && !cnt_full) begin
        d.vcnt = q.vcnt + 4'h1;
      end
      if (stop_evt) begin
        d.ctrl[`DTS_CTRL_RUN] = 1'b0;
        sev[`DTS_IRQ_DONE]    = 1'b1;
      end
    end

    // Register writes
    if (wr) begin
      case (q.addr)
        `DTS_OFF_CTRL: begin
          // A one on a live run keeps it; a zero stops it
          keep = start | d.ctrl[`DTS_CTRL_RUN];
          d.ctrl = {hwdata[7],
                    hwdata[7] & hwdata[6] & keep,
                    hwdata[5:0]};
          if (start) begin
            d.af     = 1'b0;
            d.bf     = 1'b0;
            d.a_seen = 1'b0;
            d.trig   = 1'b0;
            d.vcnt   = 4'h0;
          end
        end
        `DTS_OFF_SETUP: begin
          if (!q.ctrl[`DTS_CTRL_RUN]) begin
            d.setup = hwdata[7:0] & ~`DTS_SET_RSVD;
          end
        end
        `DTS_OFF_CMPA: d.cmpa = hwdata[15:0];
        `DTS_OFF_CMPB: d.cmpb = hwdata[15:0];
        `DTS_OFF_IRQS: clr = hwdata[2:0];
        `DTS_OFF_IRQM: d.imsk = hwdata[2:0];
        default: ;
      endcase
    end

    // Sticky events; a set in the clearing cycle wins
    d.ist = (q.ist & ~clr) | sev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) q <= '0;
    else q <= d;
  end

  assign hreadyout = q.bs != BS_RDW;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign irq       = |(q.ist & q.imsk);

  default clocking dts_clk @(posedge hclk); endclocking
  default disable iff (!hresetn);

  setup_lock_a: assert property (
    (wr && q.addr == `DTS_OFF_SETUP && q.ctrl[`DTS_CTRL_RUN]) |=> $stable(q.setup))
    else $error("setup changed while run active");
  rsvd_zero_a: assert property (
    (q.bs == BS_RDW && q.addr == `DTS_OFF_SETUP) |=> hrdata[5:4] == 2'b00)
    else $error("setup reserved bits not zero");
  qual_sel_a: assert property (
    (armed && q.setup[`DTS_SET_QSEL] && !(exec_valid && exec_addr == q.cmpa)
     && !q.af && !wr_ctrl) |=> !q.af)
    else $error("match A without executed opcode");
  status_ro_a: assert property (
    (wr && q.addr == `DTS_OFF_STATUS && !armed) |=> $stable({q.af, q.bf, q.vcnt}))
    else $error("status changed by write");
  start_clear_a: assert property (
    start |=> !q.af && !q.bf && q.vcnt == 4'h0 && armed)
    else $error("run start did not clear status");
  run_active_flag_view_a: assert property (
    (q.bs == BS_RDW && q.addr == `DTS_OFF_STATUS) |=> hrdata[5] == $past(armed))
    else $error("arm flag not mirrored");
  begin_end_a: assert property (
    (armed && begin_tr && push && q.vcnt == 4'(DEPTH - 1) && !wr_ctrl)
    |=> !armed && q.vcnt == 4'(DEPTH) ##1 hreadyout)
    else $error("begin trace did not end at full");
  end_trig_a: assert property (
    (armed && !begin_tr && hit && !wr_ctrl) |=> !armed && q.ist[`DTS_IRQ_DONE])
    else $error("end trace did not stop on trigger");
  manual_stop_a: assert property (
    (wr_ctrl && !(hwdata[`DTS_CTRL_EN] && hwdata[`DTS_CTRL_RUN])) |=> !armed)
    else $error("run not stopped by write of zero");
  cnt_hold_a: assert property (
    (pop && !push) |=> $stable(q.vcnt))
    else $error("valid count changed on read");
  evt_hibyte_a: assert property (
    (push && evonly) |-> pdata[15:8] == `DTS_EVT_HI)
    else $error("event-only word has high byte");
  then_order_a: assert property (
    (armed && mode == TM_ATHENB && !q.a_seen) |-> !hit)
    else $error("A then B triggered without A");
  cnt_max_a: assert property (q.vcnt <= 4'(DEPTH))
    else $error("valid count above depth");

  begin_run_c: cover property (armed && begin_tr && !evonly ##[1:200] stop_evt);
  end_run_c: cover property (armed && !begin_tr && hit);
  evt_store_c: cover property (push && evonly ##[1:100] stop_evt);
  irq_fire_c: cover property ($rose(irq));

endmodule // dts_top

`default_nettype wire

// >>> hw/dts_trace_fifo.sv
/*
  Trace FIFO: DEPTH words of W bits, optional overwrite of the oldest.
  Assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dts_cfg.svh"

module dts_trace_fifo
  import dts_pkg::*;
#(
  parameter int W  = `DTS_FIFO_WIDTH,
  parameter int D  = `DTS_FIFO_DEPTH,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control
  input  wire logic         clr,
  input  wire logic         ovw,
  // Fill side
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  // Drain side
  input  wire logic         pop,
  output logic      [W-1:0] rdata,
  output logic              full,
  output logic              empty
);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         n;
  } dts_fifo_st_t;

  dts_fifo_st_t q;
  dts_fifo_st_t d;

  assign full  = q.n == (AW+1)'(D);
  assign empty = q.n == '0;
  assign rdata = q.mem[q.rp];

  always_comb begin
    logic do_push;
    logic do_pop;
    d       = q;
    do_pop  = pop && !empty;
    do_push = push && (!full || ovw);
    if (clr) begin
      d.wp = '0;
      d.rp = '0;
      d.n  = '0;
    end else begin
      if (do_pop) begin
        d.rp = q.rp + 1'b1;
      end
      if (do_push) begin
        d.mem[q.wp] = wdata;
        d.wp        = q.wp + 1'b1;
        // Full ring: the oldest word is dropped
        if (full && !do_pop) begin
          d.rp = q.rp + 1'b1;
        end
      end
      case ({do_push, do_pop})
        2'b10: if (!full) d.n = q.n + 1'b1;
        2'b01: d.n = q.n - 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) q <= '0;
    else q <= d;
  end

  default clocking dts_fclk @(posedge hclk); endclocking
  default disable iff (!hresetn);

  count_bound_a: assert property (q.n <= (AW+1)'(D))
    else $error("fifo count above depth");
  ring_drop_a: assert property (
    (full && push && ovw && !pop && !clr) |=> full && q.rp == $past(q.rp) + 1'b1)
    else $error("overwrite did not drop oldest word");
  pop_adv_a: assert property (
    (pop && !empty && !push && !clr) |=> q.n == $past(q.n) - 1'b1)
    else $error("pop did not advance fifo");

endmodule // dts_trace_fifo

`default_nettype wire

// >>> testbench/dts_cpu_model.sv
/*
  CPU side model: bus monitor, opcode tracking and change-of-flow pulses.
  Assumes the bench calls its tasks and that it shares hclk with the block.
*/
`timescale 1ns/1ps
`default_nettype none

module dts_cpu_model (
  // Clock
  input  wire logic        hclk,
  // Bus monitor
  output logic             mon_valid,
  output logic      [15:0] mon_addr,
  output logic      [7:0]  mon_data,
  // Opcode tracking
  output logic             exec_valid,
  output logic      [15:0] exec_addr,
  // Change of flow
  output logic             cof_valid,
  output logic      [15:0] cof_addr
);
  initial begin
    {mon_valid, exec_valid, cof_valid} = 3'h0;
    {mon_addr, exec_addr, cof_addr} = 48'h0;
    mon_data = 8'h00;
  end

  // Lines inverted after each pulse, so stale values cannot pass for data
  task automatic access(input logic [15:0] a, input logic [7:0] d);
    @(posedge hclk);
    mon_valid <= 1'b1;
    mon_addr  <= a;
    mon_data  <= d;
    @(posedge hclk);
    mon_valid <= 1'b0;
    mon_addr  <= ~a;
    mon_data  <= ~d;
  endtask

  task automatic exec(input logic [15:0] a);
    @(posedge hclk);
    exec_valid <= 1'b1;
    exec_addr  <= a;
    @(posedge hclk);
    exec_valid <= 1'b0;
    exec_addr  <= ~a;
  endtask

  task automatic cof(input logic [15:0] a);
    @(posedge hclk);
    cof_valid <= 1'b1;
    cof_addr  <= a;
    @(posedge hclk);
    cof_valid <= 1'b0;
    cof_addr  <= ~a;
  endtask
endmodule // dts_cpu_model

`default_nettype wire

// >>> testbench/tb.sv
/*
  Self-checking bench of the debug trigger and status block.
  Assumes the block is the only AHB-Lite slave and hready is its hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dts_cfg.svh"

module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        mon_valid, exec_valid, cof_valid;
  logic [15:0] mon_addr, exec_addr, cof_addr;
  logic [7:0]  mon_data;
  logic [15:0] trig_map;
  int          failures, total_checks;

  dts_top #(.DEPTH(8)) i_dts_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mon_valid(mon_valid), .mon_addr(mon_addr), .mon_data(mon_data),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .cof_valid(cof_valid),
    .cof_addr(cof_addr), .irq(irq));

  dts_cpu_model i_dts_cpu_model (.hclk(hclk), .mon_valid(mon_valid),
    .mon_addr(mon_addr), .mon_data(mon_data), .exec_valid(exec_valid),
    .exec_addr(exec_addr), .cof_valid(cof_valid), .cof_addr(cof_addr));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Single word transfer; read data lands in v
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(v, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Stop first, since setup writes are dropped while armed
  task automatic arm(input logic [7:0] s);
    xfer(1'b1, `DTS_OFF_CTRL, 32'h0);
    xfer(1'b1, `DTS_OFF_SETUP, {24'h0, s});
    xfer(1'b1, `DTS_OFF_CTRL, 32'hc0);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    conclude();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = `DTS_HSIZE_WORD;
    failures = 0;
    total_checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`DTS_OFF_SETUP, 32'h0);
    rchk(`DTS_OFF_STATUS, 32'h0);
    rchk(8'h40, 32'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `DTS_OFF_SETUP, 32'hff);
    rchk(`DTS_OFF_SETUP, 32'hcf);
    xfer(1'b1, `DTS_OFF_CMPA, 32'h1000);
    xfer(1'b1, `DTS_OFF_CMPB, 32'h2000);
    // Armed: setup locked, arm flag mirrored, both manual stops
    arm(8'h0f);
    xfer(1'b1, `DTS_OFF_SETUP, 32'h0);
    rchk(`DTS_OFF_SETUP, 32'h0f);
    rchk(`DTS_OFF_STATUS, 32'h20);
    xfer(1'b1, `DTS_OFF_CTRL, 32'h80);
    rchk(`DTS_OFF_STATUS, 32'h0);
    xfer(1'b1, `DTS_OFF_CTRL, 32'hc0);
    xfer(1'b1, `DTS_OFF_CTRL, 32'h40);
    rchk(`DTS_OFF_STATUS, 32'h0);
    // End trace, mode A: ten stored, the oldest two overwritten
    arm(8'h00);
    for (int i = 0; i < 10; i++) i_dts_cpu_model.cof(16'h3000 + 16'(i * 257));
    i_dts_cpu_model.access(16'h1000, 8'h11);
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'h88);
    rchk(`DTS_OFF_IRQS, 32'h03);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `DTS_OFF_IRQM, 32'h7);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, `DTS_OFF_IRQS, 32'h3);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `DTS_OFF_STATUS, 32'h0);
    rchk(`DTS_OFF_STATUS, 32'h88);
    for (int i = 2; i < 4; i++) begin
      rchk(`DTS_OFF_FIFOH, 32'h30 + 32'(i));
      rchk(`DTS_OFF_FIFOH, 32'h30 + 32'(i));
      rchk(`DTS_OFF_FIFOL, 32'(i));
    end
    rchk(`DTS_OFF_STATUS, 32'h88);
    // Begin trace: nothing stored before the trigger
    arm(8'h40);
    i_dts_cpu_model.cof(16'h3f3f);
    i_dts_cpu_model.access(16'h1000, 8'h11);
    for (int i = 0; i < 8; i++) i_dts_cpu_model.cof(16'h3100 + 16'(i));
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'h88);
    rchk(`DTS_OFF_FIFOH, 32'h31);
    rchk(`DTS_OFF_FIFOL, 32'h00);
    // Qualified: access alone keeps the run, execution ends it
    arm(8'h80);
    i_dts_cpu_model.access(16'h1000, 8'h11);
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'h20);
    i_dts_cpu_model.exec(16'h1000);
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'h80);
    // Event-only with direction clear still behaves as begin trace
    arm(8'h03);
    for (int i = 0; i < 8; i++) i_dts_cpu_model.access(16'h2000, 8'h50 + 8'(i));
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'h48);
    rchk(`DTS_OFF_FIFOH, 32'h00);
    rchk(`DTS_OFF_FIFOL, 32'h50);
    // A then B: B before A is ignored, B after A ends the run
    arm(8'h02);
    i_dts_cpu_model.access(16'h2000, 8'h00);
    i_dts_cpu_model.access(16'h1000, 8'h00);
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'he0);
    i_dts_cpu_model.access(16'h2000, 8'h00);
    repeat (2) @(posedge hclk);
    rchk(`DTS_OFF_STATUS, 32'hc0);
    // Every mode code, one access at A then one above B
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 16; m++) begin
        arm(8'(m));
        i_dts_cpu_model.access(k ? 16'h2001 : 16'h1000, 8'h00);
        repeat (2) @(posedge hclk);
        xfer(1'b0, `DTS_OFF_STATUS, 32'h0);
        trig_map = k ? 16'h0100 : 16'h00a3;
        chk({31'h0, v[5]}, {31'h0, ~trig_map[m]});
      end
    end
    conclude();
  end
endmodule // tb

`default_nettype wire
